// >>> pkg/hbdd_pkg.sv
// Constants, carrier structs and state types for the descriptor DMA engine.
// Assumes 16-bit descriptor words at byte addresses, four words per entry.
package hbdd_pkg;

    // Descriptor word 0 bit positions
    localparam int OWN_BIT    = 15;
    localparam int AUXSEL_BIT = 14;
    localparam int FIRST_BIT  = 13;
    localparam int LAST_BIT   = 12;
    localparam int UI_BIT     = 11;
    localparam int IRQSUP_BIT = 10;
    localparam int RSVD_BIT   = 9;
    localparam int PF_BIT     = 8;
    localparam int ADRHI_MSB  = 7;

    // Byte offsets of the words inside one ring entry
    localparam logic [23:0] W1_OFS     = 24'h000002;
    localparam logic [23:0] W2_OFS     = 24'h000004;
    localparam logic [23:0] W3_OFS     = 24'h000006;
    localparam logic [23:0] WORD_STEP  = 24'h000002;
    localparam logic [23:0] BYTE_STEP  = 24'h000001;
    localparam int          ENTRY_SHIFT = 3;
    localparam int          IDX_W       = 7;
    localparam logic [15:0] ONE16      = 16'h0001;
    localparam logic [15:0] ZERO16     = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_RX_RD0    = 4'h1,
        ST_RX_RD1    = 4'h3,
        ST_RX_RD2    = 4'h2,
        ST_RX_WRDATA = 4'h6,
        ST_RX_WR3    = 4'h7,
        ST_RX_WR0    = 4'h5,
        ST_TX_RD0    = 4'h4,
        ST_TX_RD1    = 4'hC,
        ST_TX_RD3    = 4'hD,
        ST_TX_RDATA  = 4'hF,
        ST_TX_SEND   = 4'hE,
        ST_TX_WAIT   = 4'hA,
        ST_TX_WR0    = 4'hB
    } hbdd_state_t;

    typedef struct packed {
        logic [23:0] txRingBase;
        logic [23:0] rxRingBase;
        logic [6:0]  txRingLast;
        logic [6:0]  rxRingLast;
        logic        transparentMode;
        logic        checksumPassEnable;
    } hbdd_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic       first;
        logic       last;
        logic       ui;
        logic       pollFinal;
    } hbdd_tx_byte_t;

    typedef struct packed {
        logic [7:0] data;
        logic       fcs;
        logic       frameEnd;
    } hbdd_rx_byte_t;

    typedef struct packed {
        hbdd_state_t   st;
        logic [23:0]   addr;
        logic [15:0]   wdata;
        logic          wr;
        logic          pollTx;
        logic [15:0]   txW0;
        logic [23:0]   txPtr;
        logic [15:0]   txLeft;
        logic [15:0]   txWord;
        logic          txNew;
        hbdd_tx_byte_t txOut;
        logic          txDone;
        logic [15:0]   rxW0;
        logic [23:0]   rxPtr;
        logic [15:0]   rxLeft;
        logic [15:0]   rxCnt;
        logic [15:0]   rxWord;
        logic          rxHalf;
        logic          rxHave;
        logic          rxMid;
        logic          rxEnd;
    } hbdd_core_t;

    localparam hbdd_core_t HBDD_CORE_RST = '0;
    localparam logic [IDX_W-1:0] IDX_RST = '0;

endpackage

// >>> rtl/hbdd_ring_ptr.sv
// Ring walker: keeps the index of the current ring entry.
// Assumes the ring base is aligned to an eight-byte entry.
`timescale 1ns/1ps
module hbdd_ring_ptr
    import hbdd_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [23:0]      ringBase,
    input  wire logic [IDX_W-1:0] ringLast,
    input  wire logic             advance,
    output      logic [23:0]      descAddr
);
    logic [IDX_W-1:0] idx_ff;
    logic [IDX_W-1:0] nxt_idx;

    always_comb begin
        nxt_idx = idx_ff;
        if (advance) begin
            // Wrap after the last entry, see RULE_21
            nxt_idx = (idx_ff >= ringLast) ? IDX_RST
                                           : idx_ff + {{(IDX_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            idx_ff <= IDX_RST;
        end else begin
            idx_ff <= nxt_idx;
        end
    end

    // Four 16-bit words per entry, see RULE_20
    assign descAddr = ringBase
                    + {{(24-IDX_W-ENTRY_SHIFT){1'b0}}, idx_ff,
                       {ENTRY_SHIFT{1'b0}}};
endmodule

// >>> rtl/hbdd_dma.sv
// Descriptor DMA engine for the receive and transmit rings of a link
// controller. Assumes a 16-bit memory port with one access in flight,
// answered by memAck with read data valid in the same cycle.
// Rules from the document, for host and device
// RULE_01 - Rx word 1 holds buffer address low bits; host-written, word-aligned
// RULE_02 - Rx word 2 holds buffer length, two's complement, even, untouched
// RULE_03 - Device writes frame length, two's complement, into rx word 3
// RULE_04 - Rx buffer released without last flag is completely filled
// RULE_05 - With checksum passing, stored check bytes count in the length
// RULE_06 - Tx own bit: host sets, device clears after send and acknowledge; code waits for txAck only on last-flag buffers
// RULE_07 - A party that handed over an entry leaves its four words alone
// RULE_08 - Auxiliary owner select bit is ignored by the device
// RULE_09 - Host marks chained tx buffers with first and last flags
// RULE_10 - Tx bit 11 sends a UI frame; required in transparent mode
// RULE_11 - Tx bit 10 suppresses the done event on release
// RULE_12 - Host writes reserved tx bit 9 as zero
// RULE_13 - Tx bit 8 gives poll/final value for UI, XID, TEST frames
// RULE_14 - Tx buffer address is 24 bits over words 0 and 1
// RULE_15 - Device ignores tx word 2
// RULE_16 - Tx byte count comes from word 3, two's complement
// RULE_17 - Device clears rx own bit after filling with a good frame
// RULE_18 - Device sets rx first and last flags itself
// RULE_19 - Transparent mode releases tx entries without waiting for acknowledge
// RULE_20 - Each ring entry is four consecutive 16-bit words
// RULE_21 - After release, move to the next entry, wrapping, and wait ownership
`timescale 1ns/1ps
module hbdd_dma
    import hbdd_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire hbdd_cfg_t     cfg,
    output      logic          memReq,
    output      logic          memWrite,
    output      logic [23:0]   memAddr,
    output      logic [15:0]   memWdata,
    input  wire logic [15:0]   memRdata,
    input  wire logic          memAck,
    output      logic          txValid,
    input  wire logic          txReady,
    output      hbdd_tx_byte_t txByte,
    input  wire logic          txAck,
    output      logic          txDoneEvent,
    input  wire logic          rxValid,
    output      logic          rxReady,
    input  wire hbdd_rx_byte_t rxIn,
    output      logic [23:0]   txDescAddr,
    output      logic [23:0]   rxDescAddr
);
    hbdd_core_t  core_ff;
    hbdd_core_t  nxt_core;
    logic        keep;
    logic        flush;
    logic [15:0] newWord;
    logic [15:0] relWord;
    logic        txRel;
    logic        rxRel;

    assign txRel = (core_ff.st == ST_TX_WR0) && memAck;
    assign rxRel = (core_ff.st == ST_RX_WR0) && memAck;

    hbdd_ring_ptr u_txRing (
        .mclk     (mclk),
        .rst      (rst),
        .ringBase (cfg.txRingBase),
        .ringLast (cfg.txRingLast),
        .advance  (txRel),
        .descAddr (txDescAddr)
    );

    hbdd_ring_ptr u_rxRing (
        .mclk     (mclk),
        .rst      (rst),
        .ringBase (cfg.rxRingBase),
        .ringLast (cfg.rxRingLast),
        .advance  (rxRel),
        .descAddr (rxDescAddr)
    );

    always_comb begin
        case (core_ff.st)
            ST_RX_RD0, ST_RX_RD1, ST_RX_RD2, ST_RX_WRDATA, ST_RX_WR3,
            ST_RX_WR0, ST_TX_RD0, ST_TX_RD1, ST_TX_RD3, ST_TX_RDATA,
            ST_TX_WR0: memReq = 1'b1;
            default:   memReq = 1'b0;
        endcase
    end

    assign memWrite    = core_ff.wr;
    assign memAddr     = core_ff.addr;
    assign memWdata    = core_ff.wdata;
    assign txValid     = core_ff.st == ST_TX_SEND;
    assign txByte      = core_ff.txOut;
    assign txDoneEvent = core_ff.txDone;
    assign rxReady     = (core_ff.st == ST_IDLE) && core_ff.rxHave;

    always_comb begin
        nxt_core        = core_ff;
        nxt_core.txDone = 1'b0;
        keep            = 1'b0;
        flush           = 1'b0;
        newWord         = core_ff.rxWord;
        // Release image keeps bit 14 as found, see RULE_08
        relWord             = core_ff.rxW0;
        relWord[OWN_BIT]    = 1'b0;                     // see RULE_17
        relWord[FIRST_BIT]  = !core_ff.rxMid;           // see RULE_18
        relWord[LAST_BIT]   = core_ff.rxEnd;            // see RULE_18
        case (core_ff.st)
            ST_IDLE: begin
                if (rxValid && rxReady) begin
                    // Check bytes are kept only when passing is on
                    keep = !(rxIn.fcs && !cfg.checksumPassEnable); // see RULE_05
                    if (keep) begin
                        newWord = core_ff.rxHalf
                                ? {rxIn.data, core_ff.rxWord[7:0]}
                                : {8'h00, rxIn.data};
                        nxt_core.rxWord = newWord;
                        nxt_core.rxHalf = !core_ff.rxHalf;
                        nxt_core.rxCnt  = core_ff.rxCnt + ONE16;
                        nxt_core.rxLeft = core_ff.rxLeft - ONE16;
                    end
                    flush = (keep && (core_ff.rxHalf
                                      || core_ff.rxLeft == ONE16))
                         || (rxIn.frameEnd && (keep || core_ff.rxHalf));
                    nxt_core.rxEnd = rxIn.frameEnd;
                    if (flush) begin
                        nxt_core.st    = ST_RX_WRDATA;
                        nxt_core.addr  = {core_ff.rxPtr[23:1], 1'b0};
                        nxt_core.wr    = 1'b1;
                        nxt_core.wdata = newWord;
                    end else if (rxIn.frameEnd) begin
                        nxt_core.st    = ST_RX_WR3;
                        nxt_core.addr  = rxDescAddr + W3_OFS;
                        nxt_core.wr    = 1'b1;
                        nxt_core.wdata = ~core_ff.rxCnt + ONE16; // see RULE_03
                    end
                end else if (!core_ff.rxHave && !core_ff.pollTx) begin
                    nxt_core.st     = ST_RX_RD0;
                    nxt_core.addr   = rxDescAddr;
                    nxt_core.wr     = 1'b0;
                    nxt_core.pollTx = 1'b1;
                end else begin
                    // Alternating polls keep an unowned rx entry from
                    // starving the transmit ring
                    nxt_core.st     = ST_TX_RD0;
                    nxt_core.addr   = txDescAddr;
                    nxt_core.wr     = 1'b0;
                    nxt_core.pollTx = 1'b0;
                end
            end
            ST_RX_RD0: begin
                if (memAck) begin
                    if (memRdata[OWN_BIT]) begin                // see RULE_21
                        nxt_core.rxW0 = memRdata;
                        nxt_core.st   = ST_RX_RD1;
                        nxt_core.addr = rxDescAddr + W1_OFS;
                    end else begin
                        nxt_core.st = ST_IDLE;
                    end
                end
            end
            ST_RX_RD1: begin
                if (memAck) begin
                    nxt_core.rxPtr = {core_ff.rxW0[ADRHI_MSB:0],
                                      memRdata[15:1], 1'b0};   // see RULE_01
                    nxt_core.st    = ST_RX_RD2;
                    nxt_core.addr  = rxDescAddr + W2_OFS;
                end
            end
            ST_RX_RD2: begin
                if (memAck) begin
                    nxt_core.rxLeft = ~memRdata + ONE16;        // see RULE_02
                    nxt_core.rxHave = 1'b1;
                    nxt_core.rxHalf = 1'b0;
                    nxt_core.st     = ST_IDLE;
                end
            end
            ST_RX_WRDATA: begin
                if (memAck) begin
                    nxt_core.rxPtr  = core_ff.rxPtr + WORD_STEP;
                    nxt_core.rxHalf = 1'b0;
                    if (core_ff.rxEnd) begin
                        nxt_core.st    = ST_RX_WR3;
                        nxt_core.addr  = rxDescAddr + W3_OFS;
                        nxt_core.wdata = ~core_ff.rxCnt + ONE16; // see RULE_03
                    end else if (core_ff.rxLeft == ZERO16) begin
                        nxt_core.st    = ST_RX_WR0;              // see RULE_04
                        nxt_core.addr  = rxDescAddr;
                        nxt_core.wdata = relWord;
                    end else begin
                        nxt_core.st = ST_IDLE;
                        nxt_core.wr = 1'b0;
                    end
                end
            end
            ST_RX_WR3: begin
                if (memAck) begin
                    nxt_core.st    = ST_RX_WR0;
                    nxt_core.addr  = rxDescAddr;
                    nxt_core.wdata = relWord;
                end
            end
            ST_RX_WR0: begin
                if (memAck) begin
                    nxt_core.rxHave = 1'b0;
                    nxt_core.rxMid  = !core_ff.rxEnd;
                    nxt_core.rxEnd  = 1'b0;
                    nxt_core.wr     = 1'b0;
                    nxt_core.st     = ST_IDLE;
                    if (core_ff.rxEnd) begin
                        nxt_core.rxCnt = ZERO16;
                    end
                end
            end
            ST_TX_RD0: begin
                if (memAck) begin
                    if (memRdata[OWN_BIT]) begin          // see RULE_06
                        nxt_core.txW0 = memRdata;
                        nxt_core.st   = ST_TX_RD1;
                        nxt_core.addr = txDescAddr + W1_OFS;
                    end else begin
                        nxt_core.st = ST_IDLE;
                    end
                end
            end
            ST_TX_RD1: begin
                if (memAck) begin
                    nxt_core.txPtr = {core_ff.txW0[ADRHI_MSB:0],
                                      memRdata};           // see RULE_14
                    nxt_core.st    = ST_TX_RD3;            // see RULE_15
                    nxt_core.addr  = txDescAddr + W3_OFS;
                end
            end
            ST_TX_RD3: begin
                if (memAck) begin
                    nxt_core.txLeft = ~memRdata + ONE16;   // see RULE_16
                    nxt_core.txNew  = 1'b1;
                    if (memRdata == ZERO16) begin
                        nxt_core.st = ST_TX_WAIT;
                    end else begin
                        nxt_core.st   = ST_TX_RDATA;
                        nxt_core.addr = {core_ff.txPtr[23:1], 1'b0};
                    end
                end
            end
            ST_TX_RDATA: begin
                if (memAck) begin
                    nxt_core.txWord     = memRdata;
                    nxt_core.txOut.data = core_ff.txPtr[0] ? memRdata[15:8]
                                                           : memRdata[7:0];
                    nxt_core.txOut.first = core_ff.txW0[FIRST_BIT]
                                         && core_ff.txNew;
                    nxt_core.txOut.last  = core_ff.txW0[LAST_BIT]
                                         && core_ff.txLeft == ONE16;
                    nxt_core.txOut.ui        = core_ff.txW0[UI_BIT]; // see RULE_10
                    nxt_core.txOut.pollFinal = core_ff.txW0[PF_BIT]; // see RULE_13
                    nxt_core.st = ST_TX_SEND;
                end
            end
            ST_TX_SEND: begin
                if (txReady) begin
                    nxt_core.txNew  = 1'b0;
                    nxt_core.txPtr  = core_ff.txPtr + BYTE_STEP;
                    nxt_core.txLeft = core_ff.txLeft - ONE16;
                    if (core_ff.txLeft == ONE16) begin
                        nxt_core.st = ST_TX_WAIT;
                    end else if (core_ff.txPtr[0]) begin
                        nxt_core.st   = ST_TX_RDATA;
                        nxt_core.addr = core_ff.txPtr + BYTE_STEP;
                    end else begin
                        nxt_core.txOut.data  = core_ff.txWord[15:8];
                        nxt_core.txOut.first = 1'b0;
                        nxt_core.txOut.last  = core_ff.txW0[LAST_BIT]
                                             && core_ff.txLeft == 16'h0002;
                    end
                end
            end
            ST_TX_WAIT: begin
                // Only the frame's last buffer waits for the peer
                if (!core_ff.txW0[LAST_BIT] || cfg.transparentMode // see RULE_19
                    || txAck) begin                                 // see RULE_06
                    nxt_core.st             = ST_TX_WR0;
                    nxt_core.addr           = txDescAddr;
                    nxt_core.wr             = 1'b1;
                    nxt_core.wdata          = core_ff.txW0;
                    nxt_core.wdata[OWN_BIT] = 1'b0;
                end
            end
            ST_TX_WR0: begin
                if (memAck) begin
                    nxt_core.txDone = !core_ff.txW0[IRQSUP_BIT]; // see RULE_11
                    nxt_core.wr     = 1'b0;
                    nxt_core.st     = ST_IDLE;
                end
            end
            default: nxt_core = HBDD_CORE_RST;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            core_ff <= HBDD_CORE_RST;
        end else begin
            core_ff <= nxt_core;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_txRel;
        core_ff.st == ST_TX_WR0 && memAck;
    endsequence
    sequence s_rxRel;
        core_ff.st == ST_RX_WR0 && memAck;
    endsequence

    property p_txOwnClear;
        core_ff.st == ST_TX_WR0 && memReq |->
            memWrite && !memWdata[OWN_BIT] && memAddr == txDescAddr;
    endproperty
    a_txOwnClear: assert property (p_txOwnClear) // see RULE_06
        else $error("tx release does not clear own bit at entry");

    property p_txHoldForAck;
        core_ff.st == ST_TX_WAIT && core_ff.txW0[LAST_BIT]
            && !cfg.transparentMode && !txAck |=> core_ff.st == ST_TX_WAIT;
    endproperty
    a_txHoldForAck: assert property (p_txHoldForAck) // see RULE_06
        else $error("tx entry released before acknowledge");

    property p_transparentRelease;
        core_ff.st == ST_TX_WAIT && cfg.transparentMode
            |=> core_ff.st == ST_TX_WR0;
    endproperty
    a_transparentRelease: assert property (p_transparentRelease) // see RULE_19
        else $error("transparent release delayed");

    property p_txIrqSuppress;
        s_txRel |=> txDoneEvent == !$past(core_ff.txW0[IRQSUP_BIT]) ##1
            !txDoneEvent;
    endproperty
    a_txIrqSuppress: assert property (p_txIrqSuppress) // see RULE_11
        else $error("tx done event wrong for suppress bit");

    property p_txUiPf;
        txValid |-> txByte.ui == core_ff.txW0[UI_BIT]
            && txByte.pollFinal == core_ff.txW0[PF_BIT];
    endproperty
    a_txUiPf: assert property (p_txUiPf) // see RULE_13
        else $error("tx frame kind or poll/final mismatch");

    property p_txCount;
        core_ff.st == ST_TX_RD3 && memAck |=>
            core_ff.txLeft == ~$past(memRdata) + ONE16;
    endproperty
    a_txCount: assert property (p_txCount) // see RULE_16
        else $error("tx byte count not two's complement of word 3");

    property p_rxFullBuf;
        core_ff.st == ST_RX_WR0 && memReq && !memWdata[LAST_BIT]
            |-> core_ff.rxLeft == ZERO16;
    endproperty
    a_rxFullBuf: assert property (p_rxFullBuf) // see RULE_04
        else $error("rx buffer released partly filled");

    property p_rxRelease;
        s_rxRel |-> !memWdata[OWN_BIT]
            && memWdata[FIRST_BIT] == !core_ff.rxMid ##1 !core_ff.rxHave;
    endproperty
    a_rxRelease: assert property (p_rxRelease) // see RULE_17
        else $error("rx release image wrong");

    property p_rxLenBeforeRelease;
        core_ff.st == ST_RX_WR3 && memAck |-> memAddr == rxDescAddr + W3_OFS
            ##1 core_ff.st == ST_RX_WR0 && memWdata[LAST_BIT];
    endproperty
    a_rxLenBeforeRelease: assert property (p_rxLenBeforeRelease) // see RULE_03
        else $error("rx length not followed by last release");

    property p_writesOnlyOwned;
        memReq && memWrite |-> core_ff.st inside
            {ST_RX_WRDATA, ST_RX_WR3, ST_RX_WR0, ST_TX_WR0};
    endproperty
    a_writesOnlyOwned: assert property (p_writesOnlyOwned) // see RULE_07
        else $error("write outside owned phase");

    property p_ringAdvance;
        s_txRel |=> txDescAddr != $past(txDescAddr) || cfg.txRingLast == '0;
    endproperty
    a_ringAdvance: assert property (p_ringAdvance) // see RULE_21
        else $error("tx ring pointer did not advance");
endmodule

// >>> dv/hbdd_mem_model.sv
// Shared host memory seen by the engine: 16-bit words, byte addressed.
// Assumes one access in flight; slow stretches each answer by cycles.
`timescale 1ns/1ps
module hbdd_mem_model
(
    input  wire logic        mclk,
    input  wire logic        slow,
    input  wire logic        memReq,
    input  wire logic        memWrite,
    input  wire logic [23:0] memAddr,
    input  wire logic [15:0] memWdata,
    output      logic [15:0] memRdata,
    output      logic        memAck
);
    logic [15:0] mem [0:511];
    logic [8:0]  idx;

    assign idx = memAddr[9:1];
    // Inverted outside the answer cycle so a late sample is caught
    assign memRdata = memAck ? mem[idx] : ~mem[idx];

    initial memAck = 1'b0;

    always @(posedge mclk) begin
        memAck <= memReq && !memAck && !slow;
        if (memReq && memAck && memWrite) begin
            mem[idx] <= memWdata;
        end
    end
endmodule

// >>> dv/hbdd_dma_tb.sv
// Self-checking bench for the descriptor DMA engine.
// Assumes descriptors are placed straight into the memory model.
`timescale 1ns/1ps
module hbdd_dma_tb
    import hbdd_pkg::*;
;
    logic          mclk = 1'b0;
    logic          rst = 1'b1;
    logic          txReady = 1'b0;
    logic          txAck = 1'b0;
    logic          rxValid = 1'b0;
    logic          slow = 1'b0;
    hbdd_cfg_t     cfg;
    hbdd_rx_byte_t rxIn;
    hbdd_tx_byte_t txByte;
    logic          memReq, memWrite, memAck, txValid, txDoneEvent, rxReady;
    logic [23:0]   memAddr, txDescAddr, rxDescAddr;
    logic [15:0]   memWdata, memRdata;
    logic [31:0]   lfsr = 32'h0000724A;
    int            fails = 0;
    int            compares = 0;
    int            doneCnt = 0;
    int            cycles = 0;
    hbdd_tx_byte_t expTx [$];

    hbdd_dma hbdd_dma_i (.mclk(mclk), .rst(rst), .cfg(cfg),
        .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
        .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck),
        .txValid(txValid), .txReady(txReady), .txByte(txByte),
        .txAck(txAck), .txDoneEvent(txDoneEvent), .rxValid(rxValid),
        .rxReady(rxReady), .rxIn(rxIn), .txDescAddr(txDescAddr),
        .rxDescAddr(rxDescAddr));
    hbdd_mem_model hbdd_mem_model_i (.mclk(mclk), .slow(slow),
        .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
        .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));

    always #25 mclk = ~mclk;

    function automatic logic [15:0] rd(input logic [23:0] a);
        return hbdd_mem_model_i.mem[a[9:1]];
    endfunction

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Host order: buffer words first, ownership word last
    task automatic put(input logic [23:0] a, input logic [15:0] w0, w1, w2,
                       input logic [15:0] w3);
        hbdd_mem_model_i.mem[a[9:1] + 9'h001] = w1;
        hbdd_mem_model_i.mem[a[9:1] + 9'h002] = w2;
        hbdd_mem_model_i.mem[a[9:1] + 9'h003] = w3;
        hbdd_mem_model_i.mem[a[9:1]] = w0;
    endtask

    task automatic wait_free(input logic [23:0] a);
        while (rd(a) >= 16'h8000) @(negedge mclk);
        repeat (4) @(negedge mclk);
    endtask

    task automatic send_rx(input logic [7:0] d, input logic f, input logic e);
        @(posedge mclk);
        rxIn <= '{data: d, fcs: f, frameEnd: e};
        rxValid <= 1'b1;
        @(negedge mclk);
        while (!rxReady) @(negedge mclk);
        @(posedge mclk);
        rxValid <= 1'b0;
    endtask

    always @(posedge mclk) begin
        lfsr <= lfsr_step(lfsr);
        txReady <= lfsr[0] | lfsr[3];
        // Peer stays silent in transparent mode, so release cannot lean on it
        txAck <= lfsr[5] & !cfg.transparentMode;
        slow <= lfsr[7];
        cycles++;
        if (txDoneEvent) doneCnt++;
        if (txValid && txReady) begin
            check(txByte, expTx.size() ? expTx.pop_front() : 12'hFFF);
        end
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        cfg = '{txRingBase: 24'h000040, rxRingBase: 24'h000080,
                txRingLast: 7'h01, rxRingLast: 7'h01,
                transparentMode: 1'b0, checksumPassEnable: 1'b1};
        rxIn = '0;
        put(24'h000040, 16'hF900, 16'h0010, 16'h1234, 16'hFFFD);
        put(24'h000048, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        put(24'h000080, 16'h8000, 16'h0100, 16'hFFFC, 16'h0000);
        put(24'h000088, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        hbdd_mem_model_i.mem[8] = 16'h2211;
        hbdd_mem_model_i.mem[9] = 16'h0033;
        hbdd_mem_model_i.mem[16] = 16'h5544;
        // Data byte, then first, last, UI and poll/final flags
        expTx.push_back(hbdd_tx_byte_t'(12'h11B));
        expTx.push_back(hbdd_tx_byte_t'(12'h223));
        expTx.push_back(hbdd_tx_byte_t'(12'h337));
        expTx.push_back(hbdd_tx_byte_t'(12'h448));
        expTx.push_back(hbdd_tx_byte_t'(12'h554));
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        wait_free(24'h000040);
        check(rd(24'h000040), 16'h7900);
        check(doneCnt, 1);
        check(txDescAddr, 24'h000048);
        put(24'h000048, 16'hB400, 16'h0020, 16'h0000, 16'hFFFE);
        wait_free(24'h000048);
        check(rd(24'h000048), 16'h3400);
        check(doneCnt, 1);
        check(txDescAddr, 24'h000040);
        check(expTx.size(), 0);
        send_rx(8'hAA, 1'b0, 1'b0);
        send_rx(8'hBB, 1'b0, 1'b0);
        send_rx(8'hCC, 1'b1, 1'b1);
        wait_free(24'h000080);
        check(rd(24'h000100), 16'hBBAA);
        check(rd(24'h000102), 16'h00CC);
        check(rd(24'h000086), 16'hFFFD);
        check(rd(24'h000080), 16'h3000);
        check(rd(24'h000084), 16'hFFFC);
        check(rxDescAddr, 24'h000088);
        // Dropped check byte: one byte stored, length counts it alone
        put(24'h000088, 16'h8000, 16'h0110, 16'hFFFC, 16'h0000);
        @(posedge mclk);
        cfg.checksumPassEnable <= 1'b0;
        send_rx(8'hDD, 1'b0, 1'b0);
        send_rx(8'hEE, 1'b1, 1'b1);
        wait_free(24'h000088);
        check(rd(24'h000110), 16'h00DD);
        check(rd(24'h00008E), 16'hFFFF);
        check(rd(24'h000088), 16'h3000);
        check(rxDescAddr, 24'h000080);
        @(posedge mclk);
        cfg.transparentMode <= 1'b1;
        expTx.push_back(hbdd_tx_byte_t'(12'h44E));
        put(24'h000040, 16'hB800, 16'h0020, 16'h0000, 16'hFFFF);
        wait_free(24'h000040);
        check(rd(24'h000040), 16'h3800);
        check(doneCnt, 2);
        check(expTx.size(), 0);
        check(txDescAddr, 24'h000048);
        give_verdict();
    end
endmodule
